// *** logic/gpio_pkg.sv ***
// Summary of operation
// - Port B is eight bits with per-pin pull-ups
// - Port C is seven bits with per-pin pull-ups
// - Port D is eight bits with per-pin pull-ups
// - Port E is four bits with per-pin pull-ups
// - All pins float during reset; with no clock only a low on C6 floats them
// - Clock fuse makes B6 the oscillator input
// - Clock fuse makes B7 the oscillator output
// - RC clock plus async select: B7:6 timer oscillator
// - Reset-disable fuse programmed makes C6 plain I/O
// - Long low on C6 resets device without clock
package gpio_pkg;

	// ----------------------------------------
	// Port widths
	// ----------------------------------------
	localparam int PB_W = 8;
	localparam int PC_W = 7;
	localparam int PD_W = 8;
	localparam int PE_W = 4;

	// ----------------------------------------
	// Register map, byte addresses
	// ----------------------------------------
	localparam logic [7:0] OFS_PORT_B = 8'h00;
	localparam logic [7:0] OFS_PORT_C = 8'h10;
	localparam logic [7:0] OFS_PORT_D = 8'h20;
	localparam logic [7:0] OFS_PORT_E = 8'h30;
	localparam logic [7:0] OFS_CONFIG = 8'h40;
	// Register within a port block, address bits 3:2
	localparam logic [1:0] SUB_DIR = 2'h0;
	localparam logic [1:0] SUB_OUT = 2'h1;
	localparam logic [1:0] SUB_PULL = 2'h2;
	localparam logic [1:0] SUB_IN = 2'h3;

	// ----------------------------------------
	// Config register fields
	// ----------------------------------------
	localparam int CFG_ASYNC_BIT = 0;
	localparam int CFG_CLKSRC_LSB = 1;
	localparam int CFG_RSTDIS_BIT = 3;
	localparam logic CFG_ASYNC_RST = 1'b0;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [7:0] DIR_RST = 8'h00;
	localparam logic [7:0] OUT_RST = 8'h00;
	localparam logic [7:0] PULL_RST = 8'h00;
	localparam logic [1:0] CLKSRC_FUSE_RST = 2'h0;
	localparam logic RSTDIS_FUSE_RST = 1'b0;

	// Clock source chosen by the clock-selection fuses
	typedef enum logic [1:0] {
		CLK_CRYSTAL,
		CLK_RC_INT,
		CLK_EXT,
		CLK_SPARE
	} clk_src_t;

endpackage

// *** logic/port_if.sv ***
`timescale 1ns/1ps
// Register strobes down, register and pin state up
interface port_if #(parameter int W = 8);
	logic we_dir;
	logic we_out;
	logic we_pull;
	logic [W-1:0] wdata;
	logic [W-1:0] dir;
	logic [W-1:0] out;
	logic [W-1:0] pull;
	logic [W-1:0] pin_sync;

	modport ctl(output we_dir, output we_out, output we_pull, output wdata,
		input dir, input out, input pull, input pin_sync);
	modport port(input we_dir, input we_out, input we_pull, input wdata,
		output dir, output out, output pull, output pin_sync);
endinterface

// *** logic/port_regs.sv ***
`timescale 1ns/1ps
// One port: direction, output and pull-up registers, input synchroniser
module port_regs #(
	parameter int W = 8
) (
	input wire logic clk_i, // Core clock
	input wire logic rst_i, // Core reset, sync, high
	input wire logic [W-1:0] pin_i, // Raw pin levels
	port_if.port bus // Register side
);

	logic [W-1:0] dir_reg;
	logic [W-1:0] out_reg;
	logic [W-1:0] pull_reg;
	logic [W-1:0] meta_reg;
	logic [W-1:0] sync_reg;

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_reg <= gpio_pkg::DIR_RST[W-1:0];
			out_reg <= gpio_pkg::OUT_RST[W-1:0];
			pull_reg <= gpio_pkg::PULL_RST[W-1:0];
		end else begin
			if (bus.we_dir) dir_reg <= bus.wdata;
			if (bus.we_out) out_reg <= bus.wdata;
			if (bus.we_pull) pull_reg <= bus.wdata;
		end
	end

	// Pins are asynchronous to the core, two stages before use
	always_ff @(posedge clk_i) begin
		meta_reg <= pin_i;
		sync_reg <= meta_reg;
	end

	assign bus.dir = dir_reg;
	assign bus.out = out_reg;
	assign bus.pull = pull_reg;
	assign bus.pin_sync = sync_reg;

endmodule

// *** logic/gpio_ports.sv ***
// Design decisions made here: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
// Four general-purpose ports behind a classic Wishbone slave
module gpio_ports (
	input wire logic clk_i, // Core clock, 10 MHz
	input wire logic rst_i, // Reset, sync, high
	input wire logic [7:0] wb_adr_i, // Byte address
	input wire logic [31:0] wb_dat_i, // Write data
	input wire logic [3:0] wb_sel_i, // Byte enables
	input wire logic wb_we_i, // Write
	input wire logic wb_cyc_i, // Cycle
	input wire logic wb_stb_i, // Strobe
	output logic [31:0] wb_dat_o, // Read data
	output logic wb_ack_o, // Acknowledge
	input wire logic [gpio_pkg::PB_W-1:0] pb_in_i, // Port B pin level
	output logic [gpio_pkg::PB_W-1:0] pb_out_o, // Port B drive value
	output logic [gpio_pkg::PB_W-1:0] pb_oe_o, // Port B driver on
	output logic [gpio_pkg::PB_W-1:0] pb_pull_o, // Port B pull-up on
	input wire logic [gpio_pkg::PC_W-1:0] pc_in_i, // Port C pin level
	output logic [gpio_pkg::PC_W-1:0] pc_out_o, // Port C drive value
	output logic [gpio_pkg::PC_W-1:0] pc_oe_o, // Port C driver on
	output logic [gpio_pkg::PC_W-1:0] pc_pull_o, // Port C pull-up on
	input wire logic [gpio_pkg::PD_W-1:0] pd_in_i, // Port D pin level
	output logic [gpio_pkg::PD_W-1:0] pd_out_o, // Port D drive value
	output logic [gpio_pkg::PD_W-1:0] pd_oe_o, // Port D driver on
	output logic [gpio_pkg::PD_W-1:0] pd_pull_o, // Port D pull-up on
	input wire logic [gpio_pkg::PE_W-1:0] pe_in_i, // Port E pin level
	output logic [gpio_pkg::PE_W-1:0] pe_out_o, // Port E drive value
	output logic [gpio_pkg::PE_W-1:0] pe_oe_o, // Port E driver on
	output logic [gpio_pkg::PE_W-1:0] pe_pull_o, // Port E pull-up on
	input wire logic [1:0] clk_src_fuse_i, // Clock-selection fuses
	input wire logic reset_pin_disable_fuse_i, // High: programmed
	output logic crystal_amp_en_o, // Oscillator amp owns pins
	output logic timer_osc_en_o, // Timer oscillator owns pins
	output logic device_reset_o // Reset from rst_i or the reset pin
);

	// ----------------------------------------
	// Fuse and reset-pin synchronisers
	// ----------------------------------------
	logic [1:0] clksrc_meta_reg;
	logic [1:0] clksrc_reg;
	logic rstdis_meta_reg;
	logic rstdis_reg;
	logic rstpin_meta_reg;
	logic rstpin_reg;

	// Fuses are static, but still cross in from outside the clock domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clksrc_meta_reg <= gpio_pkg::CLKSRC_FUSE_RST;
			clksrc_reg <= gpio_pkg::CLKSRC_FUSE_RST;
			rstdis_meta_reg <= gpio_pkg::RSTDIS_FUSE_RST;
			rstdis_reg <= gpio_pkg::RSTDIS_FUSE_RST;
		end else begin
			clksrc_meta_reg <= clk_src_fuse_i;
			clksrc_reg <= clksrc_meta_reg;
			rstdis_meta_reg <= reset_pin_disable_fuse_i;
			rstdis_reg <= rstdis_meta_reg;
		end
	end

	// Reset pin level, resting high so a reset does not hold itself
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rstpin_meta_reg <= 1'b1;
			rstpin_reg <= 1'b1;
		end else begin
			rstpin_meta_reg <= pc_in_i[6];
			rstpin_reg <= rstpin_meta_reg;
		end
	end

	// Raw path works with no clock; glitches float the pins, drop the oscillator enables and pulse device_reset_o
	wire pin_rst_async = ~pc_in_i[6] & ~rstdis_reg;
	wire pin_rst_sync = ~rstpin_reg & ~rstdis_reg;
	wire core_rst = rst_i | pin_rst_sync;

	// ----------------------------------------
	// Pin ownership
	// ----------------------------------------
	gpio_pkg::clk_src_t clk_src;
	logic async_sel_reg;

	assign clk_src = gpio_pkg::clk_src_t'(clksrc_reg);
	wire osc_in_used = (clk_src == gpio_pkg::CLK_CRYSTAL) || (clk_src == gpio_pkg::CLK_EXT);
	wire osc_out_used = (clk_src == gpio_pkg::CLK_CRYSTAL);
	wire tosc_used = (clk_src == gpio_pkg::CLK_RC_INT) && async_sel_reg;
	wire [gpio_pkg::PB_W-1:0] mask_b = {~(osc_out_used | tosc_used), ~(osc_in_used | tosc_used), 6'h3f};
	wire [gpio_pkg::PC_W-1:0] mask_c = {rstdis_reg, 6'h3f};

	// ----------------------------------------
	// Port register slices
	// ----------------------------------------
	port_if #(.W(gpio_pkg::PB_W)) b_if();
	port_if #(.W(gpio_pkg::PC_W)) c_if();
	port_if #(.W(gpio_pkg::PD_W)) d_if();
	port_if #(.W(gpio_pkg::PE_W)) e_if();

	port_regs #(.W(gpio_pkg::PB_W)) u_port_b (.clk_i(clk_i), .rst_i(core_rst), .pin_i(pb_in_i), .bus(b_if.port));
	port_regs #(.W(gpio_pkg::PC_W)) u_port_c (.clk_i(clk_i), .rst_i(core_rst), .pin_i(pc_in_i), .bus(c_if.port));
	port_regs #(.W(gpio_pkg::PD_W)) u_port_d (.clk_i(clk_i), .rst_i(core_rst), .pin_i(pd_in_i), .bus(d_if.port));
	port_regs #(.W(gpio_pkg::PE_W)) u_port_e (.clk_i(clk_i), .rst_i(core_rst), .pin_i(pe_in_i), .bus(e_if.port));

	// ----------------------------------------
	// Wishbone decode
	// ----------------------------------------
	logic ack_reg;
	logic [31:0] dat_reg;

	// Index of the port block an address falls in, or none
	function automatic logic [2:0] port_hit(input logic [7:0] adr);
		port_hit = 3'h4;
		if (adr[7:6] == 2'h0 && adr[1:0] == 2'h0) port_hit = {1'b0, adr[5:4]};
	endfunction

	wire [2:0] hit = port_hit(wb_adr_i);
	wire [1:0] sub = wb_adr_i[3:2];
	wire req = wb_cyc_i & wb_stb_i;
	// Writes land on the edge at which the master sees ack
	wire wr_go = req & wb_we_i & ack_reg & wb_sel_i[0];
	wire cfg_hit = (wb_adr_i == gpio_pkg::OFS_CONFIG);
	wire wr_b = wr_go && hit == gpio_pkg::OFS_PORT_B[6:4];
	wire wr_c = wr_go && hit == gpio_pkg::OFS_PORT_C[6:4];
	wire wr_d = wr_go && hit == gpio_pkg::OFS_PORT_D[6:4];
	wire wr_e = wr_go && hit == gpio_pkg::OFS_PORT_E[6:4];

	assign b_if.we_dir = wr_b && sub == gpio_pkg::SUB_DIR;
	assign b_if.we_out = wr_b && sub == gpio_pkg::SUB_OUT;
	assign b_if.we_pull = wr_b && sub == gpio_pkg::SUB_PULL;
	assign b_if.wdata = wb_dat_i[gpio_pkg::PB_W-1:0];
	assign c_if.we_dir = wr_c && sub == gpio_pkg::SUB_DIR;
	assign c_if.we_out = wr_c && sub == gpio_pkg::SUB_OUT;
	assign c_if.we_pull = wr_c && sub == gpio_pkg::SUB_PULL;
	assign c_if.wdata = wb_dat_i[gpio_pkg::PC_W-1:0];
	assign d_if.we_dir = wr_d && sub == gpio_pkg::SUB_DIR;
	assign d_if.we_out = wr_d && sub == gpio_pkg::SUB_OUT;
	assign d_if.we_pull = wr_d && sub == gpio_pkg::SUB_PULL;
	assign d_if.wdata = wb_dat_i[gpio_pkg::PD_W-1:0];
	assign e_if.we_dir = wr_e && sub == gpio_pkg::SUB_DIR;
	assign e_if.we_out = wr_e && sub == gpio_pkg::SUB_OUT;
	assign e_if.we_pull = wr_e && sub == gpio_pkg::SUB_PULL;
	assign e_if.wdata = wb_dat_i[gpio_pkg::PE_W-1:0];

	// Pick one register of a port; inputs show the pins after the synchroniser
	function automatic logic [7:0] pick(input logic [1:0] s, input logic [7:0] d, input logic [7:0] o,
		input logic [7:0] p, input logic [7:0] i);
		case (s)
			gpio_pkg::SUB_DIR: pick = d;
			gpio_pkg::SUB_OUT: pick = o;
			gpio_pkg::SUB_PULL: pick = p;
			default: pick = i;
		endcase
	endfunction

	wire [7:0] rd_b = pick(sub, b_if.dir, b_if.out, b_if.pull, b_if.pin_sync);
	wire [7:0] rd_c = pick(sub, {1'b0, c_if.dir}, {1'b0, c_if.out}, {1'b0, c_if.pull}, {1'b0, c_if.pin_sync});
	wire [7:0] rd_d = pick(sub, d_if.dir, d_if.out, d_if.pull, d_if.pin_sync);
	wire [7:0] rd_e = pick(sub, {4'h0, e_if.dir}, {4'h0, e_if.out}, {4'h0, e_if.pull}, {4'h0, e_if.pin_sync});
	wire [7:0] rd_cfg = {4'h0, rstdis_reg, clksrc_reg, async_sel_reg};
	// Unmapped addresses still answer, with zero
	wire [7:0] rd_mux = cfg_hit ? rd_cfg :
		(hit == 3'h0) ? rd_b : (hit == 3'h1) ? rd_c : (hit == 3'h2) ? rd_d : (hit == 3'h3) ? rd_e : 8'h00;

	// Ack one cycle after the request, dropped the cycle after
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			ack_reg <= 1'b0;
			dat_reg <= 32'h0000_0000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (req & ~ack_reg) dat_reg <= {24'h00_0000, rd_mux};
		end
	end

	// Async timer oscillator select
	always_ff @(posedge clk_i) begin
		if (core_rst) begin
			async_sel_reg <= gpio_pkg::CFG_ASYNC_RST;
		end else if (wr_go && cfg_hit) begin
			async_sel_reg <= wb_dat_i[gpio_pkg::CFG_ASYNC_BIT];
		end
	end

	assign wb_ack_o = ack_reg;
	assign wb_dat_o = dat_reg;

	// ----------------------------------------
	// Pad control flops
	// ----------------------------------------
	// Pull-up only where the pin is a GPIO input with its driver off
	wire [gpio_pkg::PB_W-1:0] pb_pull_next = b_if.pull & ~b_if.dir & mask_b;
	wire [gpio_pkg::PC_W-1:0] pc_pull_next = c_if.pull & ~c_if.dir & mask_c;
	wire [gpio_pkg::PD_W-1:0] pd_pull_next = d_if.pull & ~d_if.dir;
	wire [gpio_pkg::PE_W-1:0] pe_pull_next = e_if.pull & ~e_if.dir;

	// Async clear from the reset pin: floats pads even with no clock
	always_ff @(posedge clk_i or posedge pin_rst_async) begin
		if (pin_rst_async) begin
			{pb_out_o, pb_oe_o, pb_pull_o} <= '0;
			{pc_out_o, pc_oe_o, pc_pull_o} <= '0;
			{pd_out_o, pd_oe_o, pd_pull_o} <= '0;
			{pe_out_o, pe_oe_o, pe_pull_o} <= '0;
		end else if (core_rst) begin
			{pb_out_o, pb_oe_o, pb_pull_o} <= '0;
			{pc_out_o, pc_oe_o, pc_pull_o} <= '0;
			{pd_out_o, pd_oe_o, pd_pull_o} <= '0;
			{pe_out_o, pe_oe_o, pe_pull_o} <= '0;
		end else begin
			{pb_out_o, pb_oe_o, pb_pull_o} <= {b_if.out & mask_b, b_if.dir & mask_b, pb_pull_next};
			{pc_out_o, pc_oe_o, pc_pull_o} <= {c_if.out & mask_c, c_if.dir & mask_c, pc_pull_next};
			{pd_out_o, pd_oe_o, pd_pull_o} <= {d_if.out, d_if.dir, pd_pull_next};
			{pe_out_o, pe_oe_o, pe_pull_o} <= {e_if.out, e_if.dir, pe_pull_next};
		end
	end

	// Function outputs and the reset indication
	always_ff @(posedge clk_i or posedge pin_rst_async) begin
		if (pin_rst_async) begin
			crystal_amp_en_o <= 1'b0;
			timer_osc_en_o <= 1'b0;
			device_reset_o <= 1'b1;
		end else begin
			crystal_amp_en_o <= ~core_rst & osc_in_used;
			timer_osc_en_o <= ~core_rst & tosc_used;
			device_reset_o <= core_rst;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	wire all_gpio_b = (clk_src == gpio_pkg::CLK_RC_INT) && !async_sel_reg;

	AST_RESET_FLOATS: assert property (@(posedge clk_i) core_rst |=>
		(pb_oe_o == '0 && pc_oe_o == '0 && pd_oe_o == '0 && pe_oe_o == '0 && pb_pull_o == '0))
		else $error("pads driven or pulled after reset");
	AST_PULL_NOT_DRIVEN: assert property (@(posedge clk_i) disable iff (rst_i)
		((pb_pull_o & pb_oe_o) == '0) && ((pc_pull_o & pc_oe_o) == '0) && ((pd_pull_o & pd_oe_o) == '0)
		&& ((pe_pull_o & pe_oe_o) == '0))
		else $error("pull-up on while driver is on");
	AST_B_DIR_TO_OE: assert property (@(posedge clk_i) disable iff (core_rst)
		b_if.we_dir && all_gpio_b ##1 all_gpio_b |=> pb_oe_o == $past(wb_dat_i[7:0], 2))
		else $error("port B direction write not seen on drivers");
	AST_C_OUT_TO_PIN: assert property (@(posedge clk_i) disable iff (core_rst)
		c_if.we_out |=> ##1 pc_out_o[5:0] == $past(wb_dat_i[5:0], 2))
		else $error("port C output write not seen on pins");
	AST_D_OUT_TO_PIN: assert property (@(posedge clk_i) disable iff (core_rst)
		d_if.we_out |=> ##1 pd_out_o == $past(wb_dat_i[7:0], 2))
		else $error("port D output write not seen on pins");
	AST_E_PULL: assert property (@(posedge clk_i) disable iff (core_rst)
		e_if.we_pull && e_if.dir == '0 |=> ##1 pe_pull_o == $past(wb_dat_i[3:0], 2))
		else $error("port E pull-up write not applied");
	AST_OSC_IN_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_in_used |=> !pb_oe_o[6] && !pb_pull_o[6] && crystal_amp_en_o == !$past(core_rst))
		else $error("oscillator input pin still used as I/O");
	AST_OSC_OUT_PIN: assert property (@(posedge clk_i) disable iff (rst_i)
		osc_out_used |=> !pb_oe_o[7] && !pb_pull_o[7])
		else $error("oscillator output pin still driven as I/O");
	AST_TOSC_PINS: assert property (@(posedge clk_i) disable iff (core_rst)
		tosc_used |=> timer_osc_en_o && pb_oe_o[7:6] == 2'h0)
		else $error("timer oscillator pins not released");
	AST_C6_RESET_ROLE: assert property (@(posedge clk_i) disable iff (rst_i)
		!rstdis_reg |=> !pc_oe_o[6] && !pc_pull_o[6])
		else $error("reset pin driven as I/O");
	AST_PIN_RESET: assert property (@(posedge clk_i) disable iff (rst_i)
		pin_rst_sync |=> device_reset_o && ack_reg == 1'b0)
		else $error("reset pin low did not reset");

	COV_WRITE_B: cover property (@(posedge clk_i) b_if.we_dir ##2 pb_oe_o != '0);
	COV_TOSC: cover property (@(posedge clk_i) tosc_used ##1 timer_osc_en_o);
	COV_PIN_RESET: cover property (@(posedge clk_i) pin_rst_sync ##1 device_reset_o);
	COV_C6_GPIO: cover property (@(posedge clk_i) rstdis_reg && pc_oe_o[6]);

endmodule

// *** tb/pin_board.sv ***
`timescale 1ns/1ps
// Board around one port: external drivers, pull resistors, floating lines
module pin_board #(
	parameter int W = 8,
	parameter logic [W-1:0] EXT_PULL = '0
) (
	input wire logic clk_i, // Core clock
	input wire logic [W-1:0] out_i, // Device drive value
	input wire logic [W-1:0] oe_i, // Device driver on
	input wire logic [W-1:0] pull_i, // Device pull-up on
	input wire logic [W-1:0] ext_en_i, // Board driver on
	input wire logic [W-1:0] ext_val_i, // Board drive value
	output logic [W-1:0] pin_o // Resolved level
);
	logic [W-1:0] float_reg = '0;

	// Undriven lines wander so a stale level never passes
	always @(posedge clk_i) begin
		float_reg <= ~float_reg;
	end

	// Device driver wins, then the board, then any pull
	always_comb begin
		for (int i = 0; i < W; i++) begin
			if (oe_i[i])
				pin_o[i] = out_i[i];
			else if (ext_en_i[i])
				pin_o[i] = ext_val_i[i];
			else if (pull_i[i] || EXT_PULL[i])
				pin_o[i] = 1'b1;
			else
				pin_o[i] = float_reg[i];
		end
	end
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] BASE [4] = '{gpio_pkg::OFS_PORT_B, gpio_pkg::OFS_PORT_C,
		gpio_pkg::OFS_PORT_D, gpio_pkg::OFS_PORT_E};
	localparam logic [7:0] MASK [4] = '{8'hff, 8'h7f, 8'hff, 8'h0f};
	localparam logic [7:0] OE_EXP [4] = '{8'h3f, 8'hff, 8'hbf, 8'hff};
	logic clk_i = 1'b0;
	logic clk_run = 1'b1;
	logic rst_i = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [31:0] wb_dat_i = 32'h0;
	logic [3:0] wb_sel_i = 4'h0;
	logic wb_we_i = 1'b0;
	logic wb_cyc_i = 1'b0;
	logic wb_stb_i = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, crystal_amp_en_o, timer_osc_en_o, device_reset_o;
	logic [1:0] clk_src_fuse_i = 2'h3;
	logic reset_pin_disable_fuse_i = 1'b1;
	logic [7:0] pb_in_i, pb_out_o, pb_oe_o, pb_pull_o, pd_in_i, pd_out_o, pd_oe_o, pd_pull_o;
	logic [6:0] pc_in_i, pc_out_o, pc_oe_o, pc_pull_o;
	logic [3:0] pe_in_i, pe_out_o, pe_oe_o, pe_pull_o;
	logic [7:0] ext_en [4] = '{default: 8'h00};
	logic [7:0] ext_val [4] = '{default: 8'h00};
	logic [7:0] oe_v [4], out_v [4], pull_v [4];
	int error_cnt = 0;
	int total_checks = 0;

	// Clock pauses only for the clockless reset case
	always #50 if (clk_run) clk_i = ~clk_i;

	// Per-port views, zero-extended to a byte
	assign oe_v = '{pb_oe_o, {1'b0, pc_oe_o}, pd_oe_o, {4'h0, pe_oe_o}};
	assign out_v = '{pb_out_o, {1'b0, pc_out_o}, pd_out_o, {4'h0, pe_out_o}};
	assign pull_v = '{pb_pull_o, {1'b0, pc_pull_o}, pd_pull_o, {4'h0, pe_pull_o}};

	gpio_ports i_gpio_ports (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
		.wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pb_in_i(pb_in_i), .pb_out_o(pb_out_o),
		.pb_oe_o(pb_oe_o), .pb_pull_o(pb_pull_o), .pc_in_i(pc_in_i), .pc_out_o(pc_out_o),
		.pc_oe_o(pc_oe_o), .pc_pull_o(pc_pull_o), .pd_in_i(pd_in_i), .pd_out_o(pd_out_o),
		.pd_oe_o(pd_oe_o), .pd_pull_o(pd_pull_o), .pe_in_i(pe_in_i), .pe_out_o(pe_out_o),
		.pe_oe_o(pe_oe_o), .pe_pull_o(pe_pull_o), .clk_src_fuse_i(clk_src_fuse_i),
		.reset_pin_disable_fuse_i(reset_pin_disable_fuse_i), .crystal_amp_en_o(crystal_amp_en_o),
		.timer_osc_en_o(timer_osc_en_o), .device_reset_o(device_reset_o));
	pin_board #(.W(8)) i_pin_board_b (.clk_i(clk_i), .out_i(pb_out_o), .oe_i(pb_oe_o),
		.pull_i(pb_pull_o), .ext_en_i(ext_en[0]), .ext_val_i(ext_val[0]), .pin_o(pb_in_i));
	// Reset line has a board pull-up so a released pin reads high
	pin_board #(.W(7), .EXT_PULL(7'h40)) i_pin_board_c (.clk_i(clk_i), .out_i(pc_out_o),
		.oe_i(pc_oe_o), .pull_i(pc_pull_o), .ext_en_i(ext_en[1][6:0]), .ext_val_i(ext_val[1][6:0]),
		.pin_o(pc_in_i));
	pin_board #(.W(8)) i_pin_board_d (.clk_i(clk_i), .out_i(pd_out_o), .oe_i(pd_oe_o),
		.pull_i(pd_pull_o), .ext_en_i(ext_en[2]), .ext_val_i(ext_val[2]), .pin_o(pd_in_i));
	pin_board #(.W(4)) i_pin_board_e (.clk_i(clk_i), .out_i(pe_out_o), .oe_i(pe_oe_o),
		.pull_i(pe_pull_o), .ext_en_i(ext_en[3][3:0]), .ext_val_i(ext_val[3][3:0]), .pin_o(pe_in_i));

	// ----------------------------------------
	// Bus and check tasks
	// ----------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	// Classic cycle; request held until the rising edge that samples ack high
	task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [7:0] d,
		output logic [31:0] q);
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= 4'h1;
		wb_dat_i <= {24'h0, d};
		do @(posedge clk_i); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [7:0] d);
		logic [31:0] q;
		wb_cycle(1'b1, adr, d, q);
	endtask

	task automatic rd(input logic [7:0] adr, output logic [31:0] q);
		wb_cycle(1'b0, adr, 8'h00, q);
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask

	task automatic do_reset(input int n);
		@(posedge clk_i);
		rst_i <= 1'b1;
		repeat (n) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
	endtask

	function automatic logic [7:0] ra(input int p, input logic [1:0] sub);
		return BASE[p] | {4'h0, sub, 2'b00};
	endfunction

	task automatic finish_test();
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		logic [31:0] q;
		do_reset(20);
		wait_n(1);
		for (int p = 0; p < 4; p++) begin
			check(32'(oe_v[p] | out_v[p] | pull_v[p]), 32'h0);
		end
		// Widths, drive, pull-ups and pin sampling per port
		for (int p = 0; p < 4; p++) begin
			wr(ra(p, gpio_pkg::SUB_DIR), 8'hff);
			wr(ra(p, gpio_pkg::SUB_OUT), 8'ha5);
			wr(ra(p, gpio_pkg::SUB_PULL), 8'hff);
			wait_n(3);
			rd(ra(p, gpio_pkg::SUB_DIR), q);
			check(q, 32'(MASK[p]));
			check(32'(oe_v[p]), 32'(MASK[p]));
			check(32'(out_v[p]), 32'(MASK[p] & 8'ha5));
			check(32'(pull_v[p]), 32'h0);
			rd(ra(p, gpio_pkg::SUB_IN), q);
			check(q, 32'(MASK[p] & 8'ha5));
			wr(ra(p, gpio_pkg::SUB_DIR), 8'h0f);
			wait_n(3);
			check(32'(pull_v[p]), 32'(MASK[p] & 8'hf0));
			rd(ra(p, gpio_pkg::SUB_IN), q);
			check(q, 32'(MASK[p] & 8'hf5));
			wr(ra(p, gpio_pkg::SUB_DIR), 8'h00);
			wr(ra(p, gpio_pkg::SUB_PULL), 8'h00);
			@(posedge clk_i);
			ext_en[p] <= 8'hff;
			ext_val[p] <= 8'h3c;
			wait_n(4);
			rd(ra(p, gpio_pkg::SUB_IN), q);
			check(q, 32'(MASK[p] & 8'h3c));
			@(posedge clk_i);
			ext_en[p] <= 8'h00;
		end
		rd(8'h50, q);
		check(q, 32'h0);
		// Reset in mid-run drops every driver and pull
		wr(ra(0, gpio_pkg::SUB_DIR), 8'hf0);
		wr(ra(2, gpio_pkg::SUB_PULL), 8'hff);
		@(posedge clk_i);
		rst_i <= 1'b1;
		wait_n(3);
		for (int p = 0; p < 4; p++) begin
			check(32'(oe_v[p] | pull_v[p]), 32'h0);
		end
		@(posedge clk_i);
		rst_i <= 1'b0;
		repeat (3) @(posedge clk_i);
		// Every clock source code, with and without the timer oscillator
		for (int s = 0; s < 4; s++) begin
			@(posedge clk_i);
			clk_src_fuse_i <= 2'(s);
			do_reset(3);
			wr(ra(0, gpio_pkg::SUB_DIR), 8'hff);
			wait_n(3);
			check(32'(pb_oe_o), 32'(OE_EXP[s]));
			check(32'(crystal_amp_en_o), 32'(s == 0 || s == 2));
			rd(gpio_pkg::OFS_CONFIG, q);
			check(q, 32'(s) << gpio_pkg::CFG_CLKSRC_LSB | 32'h8);
			wr(gpio_pkg::OFS_CONFIG, 8'hff);
			wait_n(3);
			check(32'(timer_osc_en_o), 32'(s == 1));
			check(32'(pb_oe_o), s == 1 ? 32'h3f : 32'(OE_EXP[s]));
			rd(gpio_pkg::OFS_CONFIG, q);
			check(q, 32'(s) << gpio_pkg::CFG_CLKSRC_LSB | 32'h9);
		end
		// Reset pin active, pulled low while the clock is stopped
		@(posedge clk_i);
		reset_pin_disable_fuse_i <= 1'b0;
		do_reset(3);
		wr(ra(1, gpio_pkg::SUB_DIR), 8'hff);
		wr(ra(0, gpio_pkg::SUB_DIR), 8'hff);
		wait_n(3);
		check(32'(pc_oe_o), 32'h3f);
		check(32'(device_reset_o), 32'h0);
		clk_run = 1'b0;
		#1000;
		ext_en[1] = 8'h40;
		ext_val[1] = 8'h00;
		#300;
		check(32'(device_reset_o), 32'h1);
		check(32'(pc_oe_o | pc_pull_o), 32'h0);
		check(32'(pb_oe_o), 32'h0);
		clk_run = 1'b1;
		wait_n(5);
		@(posedge clk_i);
		ext_en[1] <= 8'h00;
		wait_n(6);
		check(32'(device_reset_o), 32'h0);
		rd(ra(1, gpio_pkg::SUB_DIR), q);
		check(q, 32'h0);
		finish_test();
	end

	// Watchdog, well past the few hundred cycles the tests need
	initial begin
		#2000000;
		error_cnt++;
		finish_test();
	end
endmodule
